// ==== logic/dsw_defines.vh ====
// Shared constants for the standby and write command interpreter.
// Functional notes
// R1: Timed standby opcodes enter standby at once and load timeout from sector count.
// R2: Standby while spindle already stopped skips spin-down, interface stays active.
// R3: Power-down countdown starts only once drive is back in idle.
// R4: Timeout code zero disables auto power-down, non-zero enables it.
// R5: Codes 1-240 give code*5 s; 241-251 give (code-240)*30 min.
// R6: Codes 252..255 give 21 min, 8 h, 21 min 10 s, 21 min 15 s.
// R7: Enabled timer expiring without host access puts drive into standby.
// R8: Any host access restarts the timeout from its full value.
// R9: Commands in standby still run after spindle reaches speed; code starts DMA write on spindle_at_speed or after SPIN_CYC cycles.
// R10: Immediate standby opcodes enter standby without delay.
// R11: Immediate standby leaves stored timeout untouched.
// R12: Buffer write takes one sector of 16-bit data words into the buffer.
// R13: Buffer write and buffer read share the same 512-byte buffer region.
// R14: DMA write opcodes accept sectors of 16-bit words then write media.
// R15: Host sets up its DMA channel before writing the DMA-write opcode.
// R16: DMA words move only while the device holds DMA request high.
// R17: DMA write raises exactly one interrupt after transfer ends with status.
// R18: Uncorrectable error stops DMA write at the failing sector.
// R19: DMA sector count zero means 256 sectors.
// R20: Address-mode bit picks LBA field assembly or cylinder/head/sector.
// R21: Opcode bit 0 disables retries unless write caching is enabled.
// R22: After DMA write report sectors not transferred and last sector address.
// R23: Spinning up from standby keeps busy high and withholds data requests; code does so for at most SPIN_CYC cycles.
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH
`define DSW_OP_STBY_A      8'he2
`define DSW_OP_STBY_B      8'h96
`define DSW_OP_STBYI_A     8'he0
`define DSW_OP_STBYI_B     8'h94
`define DSW_OP_WBUF        8'he8
`define DSW_OP_RBUF        8'he4
`define DSW_OP_WDMA        8'hca
`define DSW_OP_WDMA_NR     8'hcb
`define DSW_ST_BSY         7
`define DSW_ST_RDY         6
`define DSW_ST_DSC         4
`define DSW_ST_DRQ         3
`define DSW_ST_ERR         0
`define DSW_ER_CRC         7
`define DSW_ER_UNC         6
`define DSW_ER_IDN         4
`define DSW_ER_ABT         2
`define DSW_DH_LBA         6
`define DSW_DH_RESET       8'ha0
`define DSW_SECT_WORDS     256
`define DSW_CLK_HZ         25000000
`define DSW_TICK_MS        100
`define DSW_TICK_CYC       (`DSW_CLK_HZ / 1000 * `DSW_TICK_MS)
`define DSW_T_5S           50
`define DSW_T_30MIN        18000
`define DSW_T_21MIN        12600
`define DSW_T_8H           288000
`define DSW_T_21M10S       12700
`define DSW_T_21M15S       12750
`endif

// ==== logic/dsw_cmd.v ====
// Command interpreter for standby, buffer write and DMA write.
`timescale 1ns/100ps
`include "dsw_defines.vh"
module dsw_cmd #(
  parameter TICK_CYC  = `DSW_TICK_CYC,
  parameter SPIN_CYC  = 1000,
  parameter MEDIA_CYC = 64,
  parameter AW        = 8
) (
  input  wire        mclk,          // 25 MHz clock
  input  wire        rst,           // async reset, active high
  input  wire        cmd_wr,        // pulse: opcode write
  input  wire [7:0]  cmd_opcode,    // command opcode
  input  wire [7:0]  tf_count,      // sector count input
  input  wire [7:0]  tf_sector,     // sector number input
  input  wire [7:0]  tf_cyl_lo,     // cylinder low input
  input  wire [7:0]  tf_cyl_hi,     // cylinder high input
  input  wire        dh_wr,         // pulse: device/head write
  input  wire [7:0]  dh_wdata,      // device/head write data
  input  wire        host_access,   // pulse: any host access
  input  wire        pio_valid,     // PIO data word valid
  input  wire        dma_valid,     // DMA data word valid (DMACK)
  input  wire [15:0] data_in,       // host data word
  input  wire        wcache_en,     // write caching enabled
  input  wire        spindle_at_speed, // spindle at operating speed
  input  wire        media_unc,     // uncorrectable error on current sector
  input  wire        media_ready,   // media side takes words
  input  wire [AW-1:0] rbuf_addr,   // buffer read address
  output reg  [15:0] rbuf_data,     // buffer read data
  output reg         data_ready,    // ready for a data word
  output reg         dmarq,         // DMA request
  output reg         intrq,         // interrupt pulse
  output reg  [7:0]  status_flags,  // command_status_flags
  output reg  [7:0]  error_flags,   // command_error_flags
  output reg  [7:0]  drive_head,    // drive_select_and_head
  output reg  [7:0]  rem_count,     // sectors not transferred
  output reg  [27:0] last_addr,     // last sector address
  output reg         spin_cmd,      // spindle run request
  output reg         in_standby,    // standby mode
  output reg         retry_en,      // retries enabled
  output reg         media_wvalid,  // word to media valid
  output reg  [15:0] media_wdata    // word to media
);
  localparam S_IDLE = 3'd0;
  localparam S_SPIN = 3'd1;
  localparam S_PIO  = 3'd2;
  localparam S_DMA  = 3'd3;
  localparam S_DRN  = 3'd4;
  localparam S_DONE = 3'd5;

  function [18:0] tmo_ticks;
    input [7:0] c;
    reg [31:0] t;
    begin
      if (c == 8'h00)
        t = 32'h0;
      else if (c <= 8'hf0)
        t = c * `DSW_T_5S;                                  // R5
      else if (c <= 8'hfb)
        t = (c - 8'hf0) * `DSW_T_30MIN;                     // R5
      else if (c == 8'hfc)
        t = `DSW_T_21MIN;                                   // R6
      else if (c == 8'hfd)
        t = `DSW_T_8H;                                      // R6
      else if (c == 8'hfe)
        t = `DSW_T_21M10S;                                  // R6
      else
        t = `DSW_T_21M15S;                                  // R6
      // The longest interval fits in 19 bits, so the upper bits are always zero.
      tmo_ticks = t[18:0];
    end
  endfunction

  reg [15:0] sbuf [0:`DSW_SECT_WORDS-1];
  reg [2:0]  st_r;
  reg [7:0]  op_r;
  reg [18:0] tmo_load_r;
  reg [18:0] tmo_cnt_r;
  reg        tmo_run_r;
  reg [31:0] tick_cnt_r;
  reg [7:0]  wcnt_r;
  reg [8:0]  secs_left_r;
  reg [27:0] cur_addr_r;
  reg [31:0] spin_cnt_r;
  reg [15:0] fb_d0_r;
  reg [15:0] fb_d1_r;
  reg [1:0]  fb_n_r;
  reg [31:0] mcnt_r;
  wire       tick = (tick_cnt_r == TICK_CYC - 1);
  wire       is_stby = (cmd_opcode == `DSW_OP_STBY_A) || (cmd_opcode == `DSW_OP_STBY_B);
  wire       is_stbyi = (cmd_opcode == `DSW_OP_STBYI_A) || (cmd_opcode == `DSW_OP_STBYI_B);
  wire       is_wdma = ({cmd_opcode[7:1], 1'b0} == `DSW_OP_WDMA);
  // Buffer has room while fewer than two words are held; the drain side can stall it.
  wire       fb_push = (st_r == S_DMA) && dmarq && dma_valid && (fb_n_r != 2'd2); // R16
  wire       fb_pop = (fb_n_r != 2'd0) && media_ready;
  // Fill level after this edge; the registered request drops before the buffer overflows.
  wire [1:0] fb_n_nxt = fb_n_r + {1'b0, fb_push} - {1'b0, fb_pop};
  wire [27:0] start_addr = drive_head[`DSW_DH_LBA] ?
               {drive_head[3:0], tf_cyl_hi, tf_cyl_lo, tf_sector} :          // R20
               {tf_cyl_hi, tf_cyl_lo, drive_head[3:0], tf_sector};

  always @(posedge mclk) begin
    if (st_r == S_PIO && pio_valid && data_ready)
      sbuf[wcnt_r] <= data_in;                                 // R12
    rbuf_data <= sbuf[rbuf_addr];                              // R13
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE;
      op_r <= 8'h00;
      tmo_load_r <= 19'h0;
      tmo_cnt_r <= 19'h0;
      tmo_run_r <= 1'b0;
      wcnt_r <= 8'h00;
      secs_left_r <= 9'h0;
      cur_addr_r <= 28'h0;
      spin_cnt_r <= 32'h0;
      fb_d0_r <= 16'h0;
      fb_d1_r <= 16'h0;
      fb_n_r <= 2'd0;
      mcnt_r <= 32'h0;
      data_ready <= 1'b0;
      dmarq <= 1'b0;
      intrq <= 1'b0;
      status_flags <= 8'h50;
      error_flags <= 8'h00;
      drive_head <= `DSW_DH_RESET;
      rem_count <= 8'h00;
      last_addr <= 28'h0;
      spin_cmd <= 1'b1;
      in_standby <= 1'b0;
      retry_en <= 1'b1;
      media_wvalid <= 1'b0;
      media_wdata <= 16'h0;
    end else begin
      intrq <= 1'b0;
      if (dh_wr)
        drive_head <= dh_wdata;
      // Auto power-down timer runs only in idle with a non-zero timeout.
      if (host_access || cmd_wr) begin
        tmo_cnt_r <= tmo_load_r;                               // R8
      end else if (tmo_run_r && tick && st_r == S_IDLE && !in_standby) begin // R3
        if (tmo_cnt_r <= 19'h1) begin
          in_standby <= 1'b1;                                  // R7
          spin_cmd <= 1'b0;
          tmo_cnt_r <= tmo_load_r;
        end else begin
          tmo_cnt_r <= tmo_cnt_r - 19'h1;
        end
      end
      // Two-entry buffer between DMA intake and media writes.
      media_wvalid <= fb_pop;
      if (fb_pop)
        media_wdata <= fb_d0_r;
      case ({fb_push, fb_pop})
        2'b10: begin
          if (fb_n_r == 2'd0)
            fb_d0_r <= data_in;
          else
            fb_d1_r <= data_in;
          fb_n_r <= fb_n_r + 2'd1;
        end
        2'b01: begin
          fb_d0_r <= fb_d1_r;
          fb_n_r <= fb_n_r - 2'd1;
        end
        2'b11: begin
          if (fb_n_r == 2'd1)
            fb_d0_r <= data_in;
          else begin
            fb_d0_r <= fb_d1_r;
            fb_d1_r <= data_in;
          end
        end
        default: begin
        end
      endcase
      case (st_r)
        S_IDLE: begin
          if (cmd_wr) begin
            op_r <= cmd_opcode;
            error_flags <= 8'h00;
            status_flags <= 8'h80;
            if (is_stby) begin
              tmo_load_r <= tmo_ticks(tf_count);               // R1
              tmo_cnt_r <= tmo_ticks(tf_count);
              tmo_run_r <= (tf_count != 8'h00);                // R4
              in_standby <= 1'b1;                              // R1
              spin_cmd <= 1'b0;                                // R2
              st_r <= S_DONE;
            end else if (is_stbyi) begin
              in_standby <= 1'b1;                              // R10 R11
              spin_cmd <= 1'b0;
              st_r <= S_DONE;
            end else if (cmd_opcode == `DSW_OP_WBUF) begin
              wcnt_r <= 8'h00;
              st_r <= S_PIO;
            end else if (is_wdma) begin
              secs_left_r <= (tf_count == 8'h00) ? 9'h100 : {1'b0, tf_count}; // R19
              cur_addr_r <= start_addr;
              last_addr <= start_addr;
              retry_en <= wcache_en | ~cmd_opcode[0];          // R21
              wcnt_r <= 8'h00;
              spin_cmd <= 1'b1;
              spin_cnt_r <= 32'h0;
              st_r <= (in_standby || !spindle_at_speed) ? S_SPIN : S_DMA; // R9
            end else begin
              error_flags <= 8'h04;
              st_r <= S_DONE;
            end
          end
        end
        S_SPIN: begin
          status_flags <= 8'h80;                               // R23
          if (spindle_at_speed || spin_cnt_r == SPIN_CYC - 1) begin
            in_standby <= 1'b0;
            st_r <= S_DMA;
          end else
            spin_cnt_r <= spin_cnt_r + 32'h1;
        end
        S_PIO: begin
          status_flags <= 8'h58;
          data_ready <= 1'b1;
          if (pio_valid && data_ready) begin
            wcnt_r <= wcnt_r + 8'h01;
            if (wcnt_r == 8'hff) begin
              data_ready <= 1'b0;
              st_r <= S_DONE;
            end
          end
        end
        S_DMA: begin
          status_flags <= 8'h58;
          dmarq <= (fb_n_nxt != 2'd2);                         // R14 R16
          if (fb_push) begin
            wcnt_r <= wcnt_r + 8'h01;
            if (wcnt_r == 8'hff) begin
              dmarq <= 1'b0;
              mcnt_r <= 32'h0;
              st_r <= S_DRN;
            end
          end
        end
        S_DRN: begin
          if (fb_n_r == 2'd0)
            mcnt_r <= mcnt_r + 32'h1;
          if (fb_n_r == 2'd0 && mcnt_r == MEDIA_CYC - 1) begin
            last_addr <= cur_addr_r;
            if (media_unc) begin
              error_flags <= 8'h40;                            // R18
              rem_count <= secs_left_r[7:0];                   // R22
              st_r <= S_DONE;
            end else if (secs_left_r == 9'h1) begin
              rem_count <= 8'h00;                              // R22
              st_r <= S_DONE;
            end else begin
              secs_left_r <= secs_left_r - 9'h1;
              cur_addr_r <= cur_addr_r + 28'h1;
              st_r <= S_DMA;
            end
          end
        end
        S_DONE: begin
          data_ready <= 1'b0;
          dmarq <= 1'b0;
          status_flags <= (error_flags != 8'h00) ? 8'h51 : 8'h50;
          intrq <= 1'b1;                                       // R17
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/dsw_cmd_props.sv ====
// Concurrent checks on the command interpreter ports.
`timescale 1ns/100ps
`include "dsw_defines.vh"
module dsw_cmd_props (
  input wire       mclk,         // clock
  input wire       rst,          // reset
  input wire       cmd_wr,       // opcode write
  input wire [7:0] cmd_opcode,   // opcode
  input wire       in_standby,   // standby
  input wire       spin_cmd,     // spindle run
  input wire [7:0] status_flags, // status
  input wire [7:0] error_flags,  // error
  input wire       intrq,        // interrupt
  input wire       dmarq,        // DMA request
  input wire       data_ready,   // word ready
  input wire       media_wvalid  // media word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = cmd_wr && !status_flags[`DSW_ST_BSY];
  wire stby = cmd_opcode == 8'he2 || cmd_opcode == 8'h96 || cmd_opcode == 8'he0 ||
              cmd_opcode == 8'h94;
  sequence s_enter;
    in_standby && !spin_cmd;
  endsequence
  sequence s_done;
    intrq && status_flags == 8'h50;
  endsequence
  property p_stby;
    take && stby |=> s_enter ##1 s_done;
  endproperty
  property p_bad;
    take && cmd_opcode == 8'h00 |-> ##[1:4] intrq && error_flags == 8'h04;
  endproperty
  property p_pulse;
    intrq |=> !intrq;
  endproperty
  property p_irq;
    intrq |-> !dmarq && !status_flags[7];
  endproperty
  property p_stop;
    !spin_cmd |-> !dmarq;
  endproperty
  property p_wake;
    take && in_standby && cmd_opcode == `DSW_OP_WDMA |=> (status_flags[7] && !dmarq) [*2];
  endproperty
  property p_wbuf;
    take && cmd_opcode == `DSW_OP_WBUF |-> ##[1:3] data_ready;
  endproperty
  property p_media;
    media_wvalid |-> spin_cmd;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby entry wrong");
  a_bad: assert property (p_bad)
    else $error("unknown opcode not aborted");
  a_pulse: assert property (p_pulse)
    else $error("interrupt longer than one cycle");
  a_irq: assert property (p_irq)
    else $error("interrupt before transfer end");
  a_stop: assert property (p_stop)
    else $error("data request with spindle stopped");
  a_wake: assert property (p_wake)
    else $error("no spin-up wait from standby");
  a_wbuf: assert property (p_wbuf)
    else $error("buffer write takes no data");
  a_media: assert property (p_media)
    else $error("media write with spindle stopped");
endmodule
bind dsw_cmd dsw_cmd_props u_dsw_cmd_props (.*);

// ==== tb/dsw_host.sv ====
// Host data port and DMA channel model feeding numbered words.
`timescale 1ns/100ps
module dsw_host (
  input  wire        mclk, // clock
  input  wire        go,   // words wanted
  input  wire        rdy,  // device takes
  input  wire        slow, // gap per word
  output reg         vld,  // word offered
  output reg  [15:0] word, // word
  output reg  [15:0] cnt   // words sent
);
  wire tk = vld && rdy && go;
  wire nv = go && !(tk && slow);
  initial begin
    vld = 1'h0;
    word = 16'h0;
    cnt = 16'h0;
  end
  // An idle bus shows the inverse so a stale word is never taken for data.
  always @(posedge mclk) begin
    if (tk) cnt <= cnt + 16'h1;
    vld <= nv;
    word <= nv ? (tk ? cnt + 16'h1 : (vld ? word : cnt)) : ~word;
  end
endmodule

// ==== tb/test_dsw_cmd.sv ====
// Self-checking bench for the standby and write command interpreter.
`timescale 1ns/100ps
`include "dsw_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_dsw_cmd;
  reg         mclk, rst, cmd_wr, dh_wr, host_access, pio_on, slow, wcache_en;
  reg         spindle_at_speed, media_unc, media_ready;
  reg  [7:0]  cmd_opcode, tf_count, tf_sector, tf_cyl_lo, tf_cyl_hi, dh_wdata, rbuf_addr;
  wire [15:0] rbuf_data, media_wdata, data_in, cnt;
  wire        data_ready, dmarq, intrq, spin_cmd, in_standby, retry_en, media_wvalid, vld;
  wire [7:0]  status_flags, error_flags, drive_head, rem_count;
  wire [27:0] last_addr;
  integer     err_total, check_count, exp_w, i;
  dsw_cmd #(.TICK_CYC(10)) u_dsw_cmd (.mclk(mclk), .rst(rst), .cmd_wr(cmd_wr),
    .cmd_opcode(cmd_opcode), .tf_count(tf_count), .tf_sector(tf_sector),
    .tf_cyl_lo(tf_cyl_lo), .tf_cyl_hi(tf_cyl_hi), .dh_wr(dh_wr), .dh_wdata(dh_wdata),
    .host_access(host_access), .pio_valid(vld & pio_on), .dma_valid(vld & dmarq & !pio_on),
    .data_in(data_in), .wcache_en(wcache_en), .spindle_at_speed(spindle_at_speed),
    .media_unc(media_unc), .media_ready(media_ready), .rbuf_addr(rbuf_addr),
    .rbuf_data(rbuf_data), .data_ready(data_ready), .dmarq(dmarq), .intrq(intrq),
    .status_flags(status_flags), .error_flags(error_flags), .drive_head(drive_head),
    .rem_count(rem_count), .last_addr(last_addr), .spin_cmd(spin_cmd),
    .in_standby(in_standby), .retry_en(retry_en), .media_wvalid(media_wvalid),
    .media_wdata(media_wdata));
  dsw_host u_dsw_host (.mclk(mclk), .go(pio_on | dmarq), .rdy(data_ready | dmarq), .slow(slow),
    .vld(vld), .word(data_in), .cnt(cnt));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (media_wvalid && media_ready) begin
    `CHK(media_wdata, exp_w[15:0])
    exp_w = exp_w + 1;
  end
  task results;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmd(input [7:0] op);
    @(posedge mclk);
    cmd_wr <= 1'h1;
    cmd_opcode <= op;
    @(posedge mclk);
    cmd_wr <= 1'h0;
  endtask
  task wait_irq;
    integer n;
    for (n = 0; n < 30000 && intrq !== 1'h1; n++) @(negedge mclk);
    if (intrq !== 1'h1) begin
      err_total++;
      results;
    end
  endtask
  task idle_chk(input integer p);
    integer n;
    repeat (p) @(negedge mclk);
    `CHK(in_standby, 1'h0)
    for (n = 0; n < 100 && in_standby !== 1'h1; n++) @(negedge mclk);
    `CHK(in_standby, 1'h1)
  endtask
  task t_wbuf;
    integer b, a;
    b = cnt;
    @(posedge mclk);
    pio_on <= 1'h1;
    cmd(`DSW_OP_WBUF);
    wait_irq;
    @(posedge mclk);
    pio_on <= 1'h0;
    `CHK(cnt, 16'(b + 256))
    for (a = 0; a < 256; a += 255) begin
      @(posedge mclk);
      rbuf_addr <= a[7:0];
      repeat (2) @(negedge mclk);
      `CHK(rbuf_data, 16'(b + a))
    end
  endtask
  task t_stby;
    reg [31:0] ops;
    ops = 32'he296e094;
    for (i = 0; i < 4; i++) begin
      cmd(ops[31 - 8 * i -: 8]);
      wait_irq;
      `CHK(in_standby, 1'h1)
      `CHK(spin_cmd, 1'h0)
    end
  endtask
  task dma(input [7:0] op, input [7:0] n, input unc, input wake);
    integer w;
    // The channel is armed before the opcode goes out.
    @(posedge mclk);
    tf_count <= n;
    media_unc <= unc;
    slow <= wake;
    spindle_at_speed <= !wake;
    media_ready <= !wake;
    w = cnt;
    exp_w = w;
    cmd(op);
    if (wake) begin
      repeat (20) @(negedge mclk);
      `CHK(status_flags, 8'h80)
      @(posedge mclk);
      spindle_at_speed <= 1'h1;
      repeat (1200) @(negedge mclk);
      `CHK(data_ready, 1'h0)
      `CHK(dmarq, 1'h0)
      @(posedge mclk);
      media_ready <= 1'h1;
    end
    wait_irq;
    `CHK(exp_w - w, unc ? 256 : 256 * n)
    `CHK(rem_count, unc ? n : 8'h00)
    `CHK(error_flags, unc ? 8'h40 : 8'h00)
    `CHK(last_addr, 28'h5543210 + (unc ? 0 : n - 1))
  endtask
  initial begin
    {rst, cmd_wr, dh_wr, host_access, pio_on, slow, wcache_en, media_unc} = 8'h80;
    {spindle_at_speed, media_ready} = 2'h3;
    {cmd_opcode, tf_count, tf_sector, tf_cyl_lo, tf_cyl_hi, dh_wdata, rbuf_addr} = 56'h0;
    {err_total, check_count, exp_w} = 96'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    `CHK({status_flags, error_flags, drive_head, spin_cmd, retry_en}, 26'h1400283)
    @(posedge mclk);
    dh_wr <= 1'h1;
    {dh_wdata, tf_sector, tf_cyl_lo, tf_cyl_hi} <= 32'he5103254;
    @(posedge mclk);
    dh_wr <= 1'h0;
    @(negedge mclk);
    `CHK(drive_head, 8'he5)
    cmd(8'h00);
    wait_irq;
    `CHK({error_flags, status_flags}, 16'h0451)
    t_wbuf;
    t_stby;
    dma(`DSW_OP_WDMA, 8'h02, 1'h0, 1'h1);
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      wcache_en <= i[0];
      dma(`DSW_OP_WDMA_NR, 8'h01, 1'h0, 1'h0);
      `CHK(retry_en, i[0])
    end
    dma(`DSW_OP_WDMA, 8'h03, 1'h1, 1'h0);
    cmd(`DSW_OP_STBY_A);
    wait_irq;
    dma(`DSW_OP_WDMA, 8'h01, 1'h0, 1'h0);
    repeat (1000) @(negedge mclk);
    @(posedge mclk);
    host_access <= 1'h1;
    @(posedge mclk);
    host_access <= 1'h0;
    idle_chk(1450);
    cmd(`DSW_OP_STBYI_A);
    wait_irq;
    dma(`DSW_OP_WDMA, 8'h01, 1'h0, 1'h0);
    idle_chk(1450);
    @(posedge mclk);
    tf_count <= 8'h00;
    cmd(`DSW_OP_STBY_A);
    wait_irq;
    dma(`DSW_OP_WDMA, 8'h01, 1'h0, 1'h0);
    repeat (2000) @(negedge mclk);
    `CHK(in_standby, 1'h0)
    results;
  end
endmodule
